// ---- dcc_consts.vh ----
// register map, field positions and reset values of the dual comparator control
// assumes a 32-bit APB slave with byte addresses and 8-bit registers in the low lanes
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH

// register byte addresses
`define DCC_ADDR_W          8
`define DCC_OFS_C1_CTRL0    8'h00
`define DCC_OFS_C1_CTRL1    8'h04
`define DCC_OFS_C2_CTRL0    8'h08
`define DCC_OFS_C2_CTRL1    8'h0C
`define DCC_OFS_MIRROR      8'h10
`define DCC_OFS_IRQ_FLAGS   8'h14
`define DCC_OFS_PORT_READ   8'h18

// control register 0 fields
`define DCC_C0_ON           7
`define DCC_C0_OUT          6
`define DCC_C0_PIN_EN       5
`define DCC_C0_INVERT       4
`define DCC_C0_SPEED        2
`define DCC_C0_HYST         1
`define DCC_C0_SYNC         0
`define DCC_CTRL0_WMASK     8'hB7
`define DCC_CTRL0_RESET     8'h04

// control register 1 fields
`define DCC_C1_RISE         7
`define DCC_C1_FALL         6
`define DCC_C1_POS_HI       5
`define DCC_C1_POS_LO       4
`define DCC_C1_NEG_HI       1
`define DCC_C1_NEG_LO       0
`define DCC_CTRL1_WMASK     8'hF3
`define DCC_CTRL1_RESET     8'h00

// mirror and flag register fields
`define DCC_MIR_C1          0
`define DCC_MIR_C2          1
`define DCC_BYTE_ZERO       8'h00

// positive input select codes and routed sources
`define DCC_PSEL_PIN        2'h0
`define DCC_PSEL_DAC        2'h1
`define DCC_PSEL_FIXED      2'h2
`define DCC_PSEL_ALT        2'h3
`define DCC_ROUTE_PIN       3'h0
`define DCC_ROUTE_DAC       3'h1
`define DCC_ROUTE_FIXED     3'h2
`define DCC_ROUTE_SHARED    3'h3
`define DCC_ROUTE_GROUND    3'h4

`endif

// ---- dcc_sync2.v ----
// two-flop synchroniser for levels entering the instruction clock domain
// assumes the caller reads only q; the first stage stays private
`timescale 1ns/1ns
`default_nettype none

module dcc_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst_n,
  // level in and out
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= {WIDTH{1'b0}};
      q    <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

// ---- dcc_channel.v ----
// one comparator's result path: polarity, timer-synchronous latch, edge flag
// assumes raw comes already synchronised and tmr_fall is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
`include "dcc_consts.vh"

module dcc_channel #(
  parameter ALT_IS_GROUND = 0
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // configuration
  input  wire       comp_on,
  input  wire       invert,
  input  wire       sync_en,
  input  wire       rise_en,
  input  wire       fall_en,
  input  wire [1:0] pos_sel,
  // events
  input  wire       raw,
  input  wire       tmr_fall,
  input  wire       flag_clr,
  // results
  output reg        result,
  output reg        ext_result,
  output reg        irq_flag,
  output reg  [2:0] pos_route
);

  // disabled comparator reads low before polarity, so on/off can make an edge
  wire next_result = (raw & comp_on) ^ invert;
  wire rise        = next_result & ~result & rise_en;
  wire fall        = ~next_result & result & fall_en;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result     <= 1'b0;
      ext_result <= 1'b0;
      irq_flag   <= 1'b0;
      pos_route  <= `DCC_ROUTE_PIN;
    end
    else
    begin
      result <= next_result;
      if (!sync_en || tmr_fall)
        ext_result <= next_result;
      if (rise || fall)
        irq_flag <= 1'b1;
      else if (flag_clr)
        irq_flag <= 1'b0;
      case (pos_sel)
        `DCC_PSEL_PIN:   pos_route <= `DCC_ROUTE_PIN;
        `DCC_PSEL_DAC:   pos_route <= `DCC_ROUTE_DAC;
        `DCC_PSEL_FIXED: pos_route <= `DCC_ROUTE_FIXED;
        default:
          pos_route <= ALT_IS_GROUND ? `DCC_ROUTE_GROUND : `DCC_ROUTE_SHARED;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- dcc_top.v ----
// top of the dual comparator control: APB register bank, two channels, port reads
// assumes analog results, prescaled timer clock and port pins arrive asynchronously
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "dcc_consts.vh"

module dcc_top (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // analog comparator front ends
  input  wire        comp1_raw,
  input  wire        comp2_raw,
  output reg         comp1_enable,
  output reg         comp2_enable,
  output reg         comp1_speed,
  output reg         comp2_speed,
  output reg         comp1_hysteresis,
  output reg         comp2_hysteresis,
  output reg  [2:0]  comp1_pos_route,
  output reg  [2:0]  comp2_pos_route,
  output reg  [1:0]  comp1_neg_select,
  output reg  [1:0]  comp2_neg_select,
  // timer clock after the prescaler
  input  wire        timer_clk_prescaled,
  // timer gate and PWM shutdown sources
  output reg         comp1_timer_gate,
  output reg         comp2_timer_gate,
  output reg         comp1_shutdown,
  output reg         comp2_shutdown,
  // interrupt flags towards the interrupt controller
  output reg         comp1_irq_flag,
  output reg         comp2_irq_flag,
  // result output pins
  input  wire        pin_direction1,
  input  wire        pin_direction2,
  output reg         result1_pin_out,
  output reg         result1_pin_oe,
  output reg         result2_pin_out,
  output reg         result2_pin_oe,
  // port read path
  input  wire [7:0]  port_pins,
  input  wire [7:0]  analog_select
);

  // reset release
  reg        rst_meta;
  reg        rst_n;

  // control registers, writable bits only
  reg  [7:0] c1_ctrl0;
  reg  [7:0] c1_ctrl1;
  reg  [7:0] c2_ctrl0;
  reg  [7:0] c2_ctrl1;

  // synchronised inputs
  wire [1:0] raw_sync;
  wire       tclk_sync;
  wire [7:0] port_sync;
  reg        tclk_prev;
  wire       tmr_fall;

  // channel results
  wire       res1;
  wire       res2;
  wire       ext1;
  wire       ext2;
  wire       flag1;
  wire       flag2;
  wire [2:0] route1;
  wire [2:0] route2;

  // bus decode
  wire       setup_phase;
  wire       access_done;
  wire       do_write;
  wire [7:0] wbyte;
  reg  [7:0] next_rbyte;
  reg        next_err;
  wire       clr1;
  wire       clr2;

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  dcc_sync2 #(.WIDTH(2)) u_raw_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({comp2_raw, comp1_raw}),
    .q     (raw_sync)
  );

  dcc_sync2 #(.WIDTH(1)) u_tclk_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (timer_clk_prescaled),
    .q     (tclk_sync)
  );

  dcc_sync2 #(.WIDTH(8)) u_port_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (port_pins),
    .q     (port_sync)
  );

  // edge taken from the prescaled clock, so the latch never races the count
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tclk_prev <= 1'b0;
    else
      tclk_prev <= tclk_sync;
  end

  assign tmr_fall = tclk_prev & ~tclk_sync;

  // APB: setup cycle prepares the answer, first access cycle completes it
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign do_write    = access_done & pwrite & ~pslverr;
  assign wbyte       = pwdata[7:0];

  // flag clear is write-one; a same-cycle edge wins inside the channel
  assign clr1 = do_write & (paddr == `DCC_OFS_IRQ_FLAGS) & wbyte[`DCC_MIR_C1];
  assign clr2 = do_write & (paddr == `DCC_OFS_IRQ_FLAGS) & wbyte[`DCC_MIR_C2];

  always @*
  begin
    next_rbyte = `DCC_BYTE_ZERO;
    next_err   = 1'b0;
    case (paddr)
      `DCC_OFS_C1_CTRL0:
        next_rbyte = (c1_ctrl0 & `DCC_CTRL0_WMASK) | ({7'h00, res1} << `DCC_C0_OUT);
      `DCC_OFS_C1_CTRL1:
        next_rbyte = c1_ctrl1 & `DCC_CTRL1_WMASK;
      `DCC_OFS_C2_CTRL0:
        next_rbyte = (c2_ctrl0 & `DCC_CTRL0_WMASK) | ({7'h00, res2} << `DCC_C0_OUT);
      `DCC_OFS_C2_CTRL1:
        next_rbyte = c2_ctrl1 & `DCC_CTRL1_WMASK;
      `DCC_OFS_MIRROR:
        next_rbyte = {6'h00, res2, res1};
      `DCC_OFS_IRQ_FLAGS:
        next_rbyte = {6'h00, flag2, flag1};
      `DCC_OFS_PORT_READ:
        next_rbyte = port_sync & ~analog_select;
      default:
        next_err = 1'b1;
    endcase
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      pready  <= 1'b1;
      prdata  <= {24'h00_0000, next_rbyte};
      pslverr <= next_err;
    end
    else if (access_done)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control register writes; read-only and unused positions are masked off
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c1_ctrl0 <= `DCC_CTRL0_RESET;
      c2_ctrl0 <= `DCC_CTRL0_RESET;
      c1_ctrl1 <= `DCC_CTRL1_RESET;
      c2_ctrl1 <= `DCC_CTRL1_RESET;
    end
    else if (do_write)
    begin
      case (paddr)
        `DCC_OFS_C1_CTRL0: c1_ctrl0 <= wbyte & `DCC_CTRL0_WMASK;
        `DCC_OFS_C1_CTRL1: c1_ctrl1 <= wbyte & `DCC_CTRL1_WMASK;
        `DCC_OFS_C2_CTRL0: c2_ctrl0 <= wbyte & `DCC_CTRL0_WMASK;
        `DCC_OFS_C2_CTRL1: c2_ctrl1 <= wbyte & `DCC_CTRL1_WMASK;
        default:           c1_ctrl0 <= c1_ctrl0;
      endcase
    end
  end

  dcc_channel #(.ALT_IS_GROUND(0)) u_chan1 (
    .clock      (clock),
    .rst_n      (rst_n),
    .comp_on    (c1_ctrl0[`DCC_C0_ON]),
    .invert     (c1_ctrl0[`DCC_C0_INVERT]),
    .sync_en    (c1_ctrl0[`DCC_C0_SYNC]),
    .rise_en    (c1_ctrl1[`DCC_C1_RISE]),
    .fall_en    (c1_ctrl1[`DCC_C1_FALL]),
    .pos_sel    (c1_ctrl1[`DCC_C1_POS_HI:`DCC_C1_POS_LO]),
    .raw        (raw_sync[0]),
    .tmr_fall   (tmr_fall),
    .flag_clr   (clr1),
    .result     (res1),
    .ext_result (ext1),
    .irq_flag   (flag1),
    .pos_route  (route1)
  );

  dcc_channel #(.ALT_IS_GROUND(1)) u_chan2 (
    .clock      (clock),
    .rst_n      (rst_n),
    .comp_on    (c2_ctrl0[`DCC_C0_ON]),
    .invert     (c2_ctrl0[`DCC_C0_INVERT]),
    .sync_en    (c2_ctrl0[`DCC_C0_SYNC]),
    .rise_en    (c2_ctrl1[`DCC_C1_RISE]),
    .fall_en    (c2_ctrl1[`DCC_C1_FALL]),
    .pos_sel    (c2_ctrl1[`DCC_C1_POS_HI:`DCC_C1_POS_LO]),
    .raw        (raw_sync[1]),
    .tmr_fall   (tmr_fall),
    .flag_clr   (clr2),
    .result     (res2),
    .ext_result (ext2),
    .irq_flag   (flag2),
    .pos_route  (route2)
  );

  // configuration copies for the analog front ends; every port leaves a flop
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comp1_enable     <= 1'b0;
      comp2_enable     <= 1'b0;
      comp1_speed      <= 1'b1;
      comp2_speed      <= 1'b1;
      comp1_hysteresis <= 1'b0;
      comp2_hysteresis <= 1'b0;
      comp1_pos_route  <= `DCC_ROUTE_PIN;
      comp2_pos_route  <= `DCC_ROUTE_PIN;
      comp1_neg_select <= 2'h0;
      comp2_neg_select <= 2'h0;
    end
    else
    begin
      comp1_enable     <= c1_ctrl0[`DCC_C0_ON];
      comp2_enable     <= c2_ctrl0[`DCC_C0_ON];
      comp1_speed      <= c1_ctrl0[`DCC_C0_SPEED];
      comp2_speed      <= c2_ctrl0[`DCC_C0_SPEED];
      comp1_hysteresis <= c1_ctrl0[`DCC_C0_HYST];
      comp2_hysteresis <= c2_ctrl0[`DCC_C0_HYST];
      comp1_pos_route  <= route1;
      comp2_pos_route  <= route2;
      comp1_neg_select <= c1_ctrl1[`DCC_C1_NEG_HI:`DCC_C1_NEG_LO];
      comp2_neg_select <= c2_ctrl1[`DCC_C1_NEG_HI:`DCC_C1_NEG_LO];
    end
  end

  // result copies for gate, shutdown and pins; costs one cycle of lag
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comp1_timer_gate <= 1'b0;
      comp2_timer_gate <= 1'b0;
      comp1_shutdown   <= 1'b0;
      comp2_shutdown   <= 1'b0;
      result1_pin_out  <= 1'b0;
      result1_pin_oe   <= 1'b0;
      result2_pin_out  <= 1'b0;
      result2_pin_oe   <= 1'b0;
    end
    else
    begin
      comp1_timer_gate <= ext1;
      comp2_timer_gate <= ext2;
      comp1_shutdown   <= res1;
      comp2_shutdown   <= res2;
      // pin drive ignores the comparator enable; only the pin enable bit and direction gate it
      result1_pin_out  <= ext1;
      result1_pin_oe   <= c1_ctrl0[`DCC_C0_PIN_EN] & ~pin_direction1;
      result2_pin_out  <= ext2;
      result2_pin_oe   <= c2_ctrl0[`DCC_C0_PIN_EN] & ~pin_direction2;
    end
  end

  // flag copies for the interrupt controller, one cycle behind the sticky flag
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comp1_irq_flag   <= 1'b0;
      comp2_irq_flag   <= 1'b0;
    end
    else
    begin
      comp1_irq_flag   <= flag1;
      comp2_irq_flag   <= flag2;
    end
  end

endmodule
`default_nettype wire

// ---- dcc_properties.sv ----
// checker for the dual comparator control top: bus handshake, reset and field routing
// assumes it is bound to dcc_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "dcc_consts.vh"

module dcc_properties (
  input wire logic        clock, resetn, psel, penable, pwrite, pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        comp1_enable, comp1_speed, comp2_speed, comp1_hysteresis,
  input wire logic [2:0]  comp2_pos_route,
  input wire logic [1:0]  comp1_neg_select,
  input wire logic        comp1_irq_flag, pin_direction1, result1_pin_oe,
  input wire logic        result1_pin_out, comp1_timer_gate
);
  wire acc = psel && penable && pready && pwrite;

  AST_PREADY_ONE: assert property (@(posedge clock) disable iff (!resetn)
    psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
  AST_UPPER_ZERO: assert property (@(posedge clock) disable iff (!resetn)
    pready |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  AST_SPEED_RESET: assert property (@(posedge clock)
    !resetn [*2] |-> comp1_speed && comp2_speed) else $error("speed not one in reset");
  AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    acc && paddr == `DCC_OFS_C1_CTRL0 |-> ##2 comp1_enable == $past(pwdata[7], 2))
    else $error("enable does not follow write");
  AST_SPEED_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    acc && paddr == `DCC_OFS_C1_CTRL0 && !pwdata[2] |-> ##2 !comp1_speed)
    else $error("speed not cleared");
  AST_HYST_ROSE: assert property (@(posedge clock) disable iff (!resetn)
    $rose(comp1_hysteresis) |-> $past(acc && paddr == `DCC_OFS_C1_CTRL0 && pwdata[1], 2))
    else $error("hysteresis rose without write");
  AST_NEG_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    acc && paddr == `DCC_OFS_C1_CTRL1 |-> ##2 comp1_neg_select == $past(pwdata[1:0], 2))
    else $error("negative select wrong");
  AST_POS_ALT: assert property (@(posedge clock) disable iff (!resetn)
    acc && paddr == `DCC_OFS_C2_CTRL1 && pwdata[5:4] == 2'h3
    |-> ##3 comp2_pos_route == `DCC_ROUTE_GROUND) else $error("code 3 not ground");
  AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
    $fell(comp1_irq_flag) |-> $past(acc && paddr == `DCC_OFS_IRQ_FLAGS && pwdata[0], 2))
    else $error("flag fell without clear");
  AST_PIN_DIR: assert property (@(posedge clock) disable iff (!resetn)
    pin_direction1 [*2] |-> !result1_pin_oe) else $error("pin driven as input");
  AST_GATE_PIN: assert property (@(posedge clock) disable iff (!resetn)
    result1_pin_out == comp1_timer_gate) else $error("gate and pin differ");
endmodule

bind dcc_top dcc_properties u_dcc_properties (.*);
`default_nettype wire

// ---- dcc_analog_model.sv ----
// far side model: two analog comparators and the prescaled timer clock
// assumes the bench sets input voltages as codes and starts the timer
`timescale 1ns/1ns
`default_nettype none

module dcc_analog_model (
  input wire logic       clock,
  input wire logic [7:0] vp1, vn1, vp2, vn2,
  input wire logic       tmr_run,
  output wire logic      comp1_raw, comp2_raw, timer_clk_prescaled
);
  logic [1:0] pre = 2'h0;
  assign comp1_raw = vp1 > vn1;
  assign comp2_raw = vp2 > vn2;
  // clock stands still while the timer is stopped
  always @(posedge clock)
  begin
    if (!tmr_run)
      pre <= 2'h0;
    else
      pre <= pre + 2'h1;
  end
  assign timer_clk_prescaled = pre[1];
endmodule
`default_nettype wire

// ---- dual_comparator_control_test.sv ----
// self-checking bench for dcc_top through APB, with the analog model beside it
// assumes the design files and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none

module dual_comparator_control_test;
  logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic tmr_run = 1'b0, pin_direction1 = 1'b1, pin_direction2 = 1'b1, sl;
  logic [7:0] paddr = 8'h00, port_pins = 8'hA5, analog_select = 8'h0F;
  logic [7:0] vp1 = 8'h00, vn1 = 8'h80, vp2 = 8'h00, vn2 = 8'h80;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  wire [31:0] prdata;
  wire [2:0] comp1_pos_route, comp2_pos_route;
  wire [1:0] comp1_neg_select, comp2_neg_select;
  wire pready, pslverr, comp1_raw, comp2_raw, timer_clk_prescaled;
  wire comp1_enable, comp2_enable, comp1_speed, comp2_speed;
  wire comp1_hysteresis, comp2_hysteresis, comp1_timer_gate, comp2_timer_gate;
  wire comp1_shutdown, comp2_shutdown, comp1_irq_flag, comp2_irq_flag;
  wire result1_pin_out, result1_pin_oe, result2_pin_out, result2_pin_oe;
  int errors = 0, tests_run = 0, cyc = 0;

  dcc_top u_dcc_top (.*);
  dcc_analog_model u_dcc_analog_model (.*);

  always #20 clock = ~clock;

  task conclude;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      conclude();
    end
  end

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(s, e, rd);
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rdc("c1 ctrl0", 8'h00, 32'h0000_0004);
    rdc("c2 ctrl0", 8'h08, 32'h0000_0004);
    rdc("c1 ctrl1", 8'h04, 32'h0000_0000);
    rdc("mirror", 8'h10, 32'h0000_0000);
    rdc("unmapped", 8'h1C, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, sl});
    wr(8'h04, 32'h0000_00FF);
    rdc("c1 ctrl1 mask", 8'h04, 32'h0000_00F3);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h04, 32'(i * 17));
      wr(8'h0C, 32'(i * 17));
      repeat (3) @(posedge clock);
      chk("neg sel", 32'(i), {30'h0, comp1_neg_select});
      chk("neg sel 2", 32'(i), {30'h0, comp2_neg_select});
      chk("pos route 1", 32'(i), {29'h0, comp1_pos_route});
      chk("pos route 2", (i == 3) ? 32'h4 : 32'(i), {29'h0, comp2_pos_route});
    end
    // raw is low, so inversion alone makes the result high
    wr(8'h00, 32'h0000_00FE);
    repeat (6) @(posedge clock);
    rdc("inverted", 8'h00, 32'h0000_00F6);
    chk("enable", 32'h1, {31'h0, comp1_enable});
    chk("hyst", 32'h1, {31'h0, comp1_hysteresis});
    chk("shutdown", 32'h1, {31'h0, comp1_shutdown});
    wr(8'h00, 32'h0000_00A2);
    repeat (6) @(posedge clock);
    rdc("plain low", 8'h00, 32'h0000_00A2);
    chk("speed", 32'h0, {31'h0, comp1_speed});
    vp1 <= 8'hFF;
    repeat (6) @(posedge clock);
    rdc("plain high", 8'h00, 32'h0000_00E2);
    rdc("mirror c1", 8'h10, 32'h0000_0001);
    chk("oe input", 32'h0, {31'h0, result1_pin_oe});
    pin_direction1 <= 1'b0;
    repeat (3) @(posedge clock);
    chk("oe out", 32'h1, {31'h0, result1_pin_oe});
    chk("pin", 32'h1, {31'h0, result1_pin_out});
    wr(8'h00, 32'h0000_0020);
    repeat (6) @(posedge clock);
    chk("oe off", 32'h1, {31'h0, result1_pin_oe});
    chk("pin off", 32'h0, {31'h0, result1_pin_out});
    wr(8'h14, 32'h0000_0003);
    wr(8'h04, 32'h0000_0080);
    wr(8'h00, 32'h0000_0080);
    repeat (6) @(posedge clock);
    chk("rise flag", 32'h1, {31'h0, comp1_irq_flag});
    rdc("flags", 8'h14, 32'h0000_0001);
    wr(8'h14, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk("cleared", 32'h0, {31'h0, comp1_irq_flag});
    vp1 <= 8'h00;
    repeat (6) @(posedge clock);
    chk("fall off", 32'h0, {31'h0, comp1_irq_flag});
    wr(8'h04, 32'h0000_0040);
    wr(8'h00, 32'h0000_0010);
    repeat (6) @(posedge clock);
    chk("rise off", 32'h0, {31'h0, comp1_irq_flag});
    wr(8'h00, 32'h0000_0000);
    repeat (6) @(posedge clock);
    chk("pol fall", 32'h1, {31'h0, comp1_irq_flag});
    // timer held still: the synchronised outputs must not move
    wr(8'h00, 32'h0000_0081);
    vp1 <= 8'hFF;
    repeat (8) @(posedge clock);
    chk("gate held", 32'h0, {31'h0, comp1_timer_gate});
    chk("internal", 32'h1, {31'h0, comp1_shutdown});
    tmr_run <= 1'b1;
    repeat (16) @(posedge clock);
    tmr_run <= 1'b0;
    chk("gate synced", 32'h1, {31'h0, comp1_timer_gate});
    rdc("port", 8'h18, 32'h0000_00A0);
    wr(8'h08, 32'h0000_0080);
    vp2 <= 8'hFF;
    repeat (6) @(posedge clock);
    wr(8'h10, 32'h0000_00FF);
    rdc("mirror both", 8'h10, 32'h0000_0003);
    chk("mirror err", 32'h0, {31'h0, sl});
    chk("shutdown 2", 32'h1, {31'h0, comp2_shutdown});
    chk("enable 2", 32'h1, {31'h0, comp2_enable});
    chk("speed 2", 32'h0, {31'h0, comp2_speed});
    chk("hyst 2", 32'h0, {31'h0, comp2_hysteresis});
    chk("gate 2", 32'h1, {31'h0, comp2_timer_gate});
    chk("pin 2", 32'h1, {31'h0, result2_pin_out});
    chk("oe 2", 32'h0, {31'h0, result2_pin_oe});
    chk("flag 2", 32'h0, {31'h0, comp2_irq_flag});
    conclude();
  end
endmodule
`default_nettype wire
